/* File: design/tiesel_regs.vh */
// Register map, field positions and reset values of the timer input unit
// Overview of operation
// - Clock channels select source and pin edge/level
// - Processed clock channel drives internal clock bus
// - Event pins give enable/measure/count toward timers
// - Processed event signals also feed event bus
// - Clock ch3: internal, rise, fall, both edges
// - Clock ch2: off, rise, fall, both, low, high
// - Clock ch1: off, rise, fall, both, low, high
// - Clock ch0: internal, rise, fall, both edges
// - Event in4: off, rise, fall, both, low, high
// - Event in3: off, rise, fall, both, low, high
`ifndef TIESEL_REGS_VH
`define TIESEL_REGS_VH

// Printed offsets are register indices; byte address is four times each
`define TIESEL_CLK_CTRL_IDX   32'h0080_0210
`define TIESEL_EVT_CTRL0_IDX  32'h0080_0212
`define TIESEL_CLK_CTRL_ADDR  (`TIESEL_CLK_CTRL_IDX << 2)
`define TIESEL_EVT_CTRL0_ADDR (`TIESEL_EVT_CTRL0_IDX << 2)

// Reset values and writable bit masks
`define TIESEL_CTRL_RESET     16'h0000
`define TIESEL_CLK_CTRL_MASK  16'h3773
`define TIESEL_EVT_CTRL0_MASK 16'h773f

// Clock control field positions (clock 3 at bits 13:12 is the left-most field)
`define TIESEL_CLK3_HI 13
`define TIESEL_CLK3_LO 12
`define TIESEL_CLK2_HI 10
`define TIESEL_CLK2_LO 8
`define TIESEL_CLK1_HI 6
`define TIESEL_CLK1_LO 4
`define TIESEL_CLK0_HI 1
`define TIESEL_CLK0_LO 0

// Event control 0 field positions
`define TIESEL_EVT4_HI 14
`define TIESEL_EVT4_LO 12
`define TIESEL_EVT3_HI 10
`define TIESEL_EVT3_LO 8
`define TIESEL_EVT2_HI 5
`define TIESEL_EVT2_LO 4
`define TIESEL_EVT1_HI 3
`define TIESEL_EVT1_LO 2
`define TIESEL_EVT0_HI 1
`define TIESEL_EVT0_LO 0

// Processing modes of a three-bit select field
`define TIESEL_MODE_OFF  3'h0
`define TIESEL_MODE_RISE 3'h1
`define TIESEL_MODE_FALL 3'h2
`define TIESEL_MODE_BOTH 3'h3

// Bus responses
`define TIESEL_RESP_OKAY   2'h0
`define TIESEL_RESP_SLVERR 2'h2

`endif

/* File: design/tiesel_top.v */
// Timer clock and event pin processing with an AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "tiesel_regs.vh"

module tiesel_top (
  input  wire        clock_in,
  input  wire        rst_in,
  // AXI4-Lite slave
  input  wire [31:0] s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [31:0] s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        s_axi_bready_unused_in,
  // Pins and internal sources
  input  wire [3:0]  external_timer_clock_pin_in,
  input  wire [4:0]  external_timer_event_pin_in,
  input  wire        internal_clock_pulse_in,
  // Toward timers and buses
  output wire [3:0]  clock_bus_out,
  output wire [4:0]  event_out
);

  localparam NPIN = 9;

  // Block outline
  // Nine pin channels in all: four clock pins, then five event pins.
  // Each channel runs the same path: three sampling stages, an agree
  // filter, then an edge or level qualifier chosen by its select field.
  // Clock channels 0 and 3 may bypass the pin entirely.
  // Code zero on those two channels forwards the internal count source.
  // Clock channels 1 and 2 instead treat code zero as input off.
  // All nine results are registered once more before leaving the block.
  // So every output comes from a flip-flop and never glitches.
  //
  // Latency
  // A pin change reaches an output at the fourth edge after it.
  // Two edges go to the first two stages, one to the third.
  // Stages two and three already agree at that third edge.
  // The last edge registers the qualified result.
  // The internal source passes in one edge, with no sampling stages.
  // That source already lives in this clock domain.
  //
  // Filtering
  // A level must be seen by two stages in a row before it counts.
  // A one-cycle spike on a pin therefore never reaches a timer.
  // The price is that pulses shorter than two cycles may be lost.
  // Users who need narrow pulses must stretch them outside.
  //
  // Edge modes
  // Rising, falling and both-edge modes give one-cycle pulses.
  // Each pulse marks one accepted change of the filtered level.
  // A timer counting these pulses sees at most one per clock.
  //
  // Level modes
  // High and low level modes hold the output for as long as the
  // filtered level stays; they suit gate or enable use by timers.
  // Only the three-bit fields can select a level mode.
  // Two-bit fields are widened with a zero, so they stay edge-only.
  //
  // Register side
  // Two 16-bit control words sit behind the AXI4-Lite slave.
  // Bits without a field never store a one and always read zero.
  // Byte lanes 0 and 1 are written independently; lanes 2 and 3
  // are dropped because nothing lives above bit 15.
  // Any other address answers SLVERR and changes nothing.
  //
  // Write handshake
  // Address and data are taken in either order, each in one beat.
  // Each ready drops once its beat is held, so a second beat waits.
  // The write lands one edge after both beats are held.
  // The response then stands until the master takes it.
  // A new write is not performed while a response is still pending.
  // That keeps one write in flight and response order obvious.
  //
  // Read handshake
  // The read data is captured at the edge that takes the address.
  // It stands, with its response code, until the master takes it.
  // The address ready stays low meanwhile, one read in flight.
  //
  // Mode change hazards
  // Changing a select field acts on the next edge after the write.
  // Switching from an edge mode to a level mode may show the level
  // at once; switching the other way may emit no pulse for the
  // change already seen, because the filter state is kept.
  // Software that needs a clean start should disable first.
  //
  // Reset
  // Synchronous reset clears every stage and both control words.
  // After reset, clock channels 0 and 3 forward the internal source
  // and all other channels are off, so timers see no pin activity.
  // The ready outputs rise one edge after reset is released.

  reg  [15:0] clk_ctrl_q;
  reg  [15:0] evt_ctrl0_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [31:0] aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [NPIN-1:0] sync1_q;
  reg  [NPIN-1:0] sync2_q;
  reg  [NPIN-1:0] sync3_q;
  reg  [NPIN-1:0] filt_q;
  reg  [NPIN-1:0] proc_q;

  wire        aw_fire;
  wire        w_fire;
  wire        ar_fire;
  wire        do_wr;
  wire        aw_have_d;
  wire        w_have_d;
  wire        bvalid_d;
  wire        rvalid_d;
  wire        wr_clk;
  wire        wr_evt;
  wire [15:0] lane_mask;
  wire [NPIN-1:0]   pins;
  wire [NPIN-1:0]   filt_d;
  wire [NPIN-1:0]   pass_int;
  wire [3*NPIN-1:0] mode;

  // Handshake terms
  assign aw_fire   = s_axi_awvalid_in & s_axi_awready_out;
  assign w_fire    = s_axi_wvalid_in & s_axi_wready_out;
  assign ar_fire   = s_axi_arvalid_in & s_axi_arready_out;
  // Hold off the write until the previous response has been taken
  assign do_wr     = aw_have_q & w_have_q & ~s_axi_bvalid_out;
  assign aw_have_d = do_wr ? 1'b0 : (aw_have_q | aw_fire);
  assign w_have_d  = do_wr ? 1'b0 : (w_have_q | w_fire);
  assign bvalid_d  = do_wr | (s_axi_bvalid_out & ~s_axi_bready_in);
  assign rvalid_d  = ar_fire | (s_axi_rvalid_out & ~s_axi_rready_in);
  assign wr_clk    = do_wr & (aw_addr_q == `TIESEL_CLK_CTRL_ADDR);
  assign wr_evt    = do_wr & (aw_addr_q == `TIESEL_EVT_CTRL0_ADDR);
  // Only the two low byte lanes reach the 16-bit registers
  assign lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Write channel: address and data accepted in either order
  always @(posedge clock_in) begin
    if (rst_in) begin
      aw_have_q         <= 1'b0;
      w_have_q          <= 1'b0;
      aw_addr_q         <= 32'h0000_0000;
      w_data_q          <= 32'h0000_0000;
      w_strb_q          <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `TIESEL_RESP_OKAY;
    end else begin
      aw_have_q         <= aw_have_d;
      w_have_q          <= w_have_d;
      s_axi_awready_out <= ~aw_have_d;
      s_axi_wready_out  <= ~w_have_d;
      s_axi_bvalid_out  <= bvalid_d;
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (do_wr) begin
        s_axi_bresp_out <= (wr_clk | wr_evt) ? `TIESEL_RESP_OKAY
                                             : `TIESEL_RESP_SLVERR;
      end
    end
  end

  // Control registers; unassigned bits never store a one
  always @(posedge clock_in) begin
    if (rst_in) begin
      clk_ctrl_q  <= `TIESEL_CTRL_RESET;
      evt_ctrl0_q <= `TIESEL_CTRL_RESET;
    end else begin
      if (wr_clk) begin
        clk_ctrl_q <= (clk_ctrl_q & ~(lane_mask & `TIESEL_CLK_CTRL_MASK))
                    | (w_data_q[15:0] & lane_mask
                       & `TIESEL_CLK_CTRL_MASK);
      end
      if (wr_evt) begin
        evt_ctrl0_q <= (evt_ctrl0_q
                        & ~(lane_mask & `TIESEL_EVT_CTRL0_MASK))
                     | (w_data_q[15:0] & lane_mask
                        & `TIESEL_EVT_CTRL0_MASK);
      end
    end
  end

  // Read channel: one answer outstanding, data from the registers
  always @(posedge clock_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `TIESEL_RESP_OKAY;
    end else begin
      s_axi_arready_out <= ~rvalid_d;
      s_axi_rvalid_out  <= rvalid_d;
      if (ar_fire) begin
        if (s_axi_araddr_in == `TIESEL_CLK_CTRL_ADDR) begin
          s_axi_rdata_out <= {16'h0000, clk_ctrl_q};
          s_axi_rresp_out <= `TIESEL_RESP_OKAY;
        end else if (s_axi_araddr_in == `TIESEL_EVT_CTRL0_ADDR) begin
          s_axi_rdata_out <= {16'h0000, evt_ctrl0_q};
          s_axi_rresp_out <= `TIESEL_RESP_OKAY;
        end else begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= `TIESEL_RESP_SLVERR;
        end
      end
    end
  end

  // Channel order: clock 0..3 in bits 0..3, event 0..4 in bits 4..8
  assign pins = {external_timer_event_pin_in, external_timer_clock_pin_in};

  // Per-channel mode; two-bit fields are edge-only, widened with a zero
  assign mode[2:0]   = {1'b0, clk_ctrl_q[`TIESEL_CLK0_HI:`TIESEL_CLK0_LO]};
  assign mode[5:3]   = clk_ctrl_q[`TIESEL_CLK1_HI:`TIESEL_CLK1_LO];
  assign mode[8:6]   = clk_ctrl_q[`TIESEL_CLK2_HI:`TIESEL_CLK2_LO];
  assign mode[11:9]  = {1'b0, clk_ctrl_q[`TIESEL_CLK3_HI:`TIESEL_CLK3_LO]};
  assign mode[14:12] = {1'b0,
                        evt_ctrl0_q[`TIESEL_EVT0_HI:`TIESEL_EVT0_LO]};
  assign mode[17:15] = {1'b0,
                        evt_ctrl0_q[`TIESEL_EVT1_HI:`TIESEL_EVT1_LO]};
  assign mode[20:18] = {1'b0,
                        evt_ctrl0_q[`TIESEL_EVT2_HI:`TIESEL_EVT2_LO]};
  assign mode[23:21] = evt_ctrl0_q[`TIESEL_EVT3_HI:`TIESEL_EVT3_LO];
  assign mode[26:24] = evt_ctrl0_q[`TIESEL_EVT4_HI:`TIESEL_EVT4_LO];

  // Code zero on clock channels 0 and 3 passes the internal clock
  assign pass_int = {5'h00,
                     (mode[11:9] == `TIESEL_MODE_OFF), 2'h0,
                     (mode[2:0] == `TIESEL_MODE_OFF)};

  // Edge or level qualifier for one channel
  function proc_fn;
    input [2:0] m;
    input       now;
    input       was;
    begin
      case (m)
        `TIESEL_MODE_OFF:  proc_fn = 1'b0;
        `TIESEL_MODE_RISE: proc_fn = now & ~was;
        `TIESEL_MODE_FALL: proc_fn = ~now & was;
        `TIESEL_MODE_BOTH: proc_fn = now ^ was;
        3'h4, 3'h5:        proc_fn = ~now; // Low level, held while low
        default:           proc_fn = now;  // High level, held while high
      endcase
    end
  endfunction

  // Three-stage synchroniser, a change taken once stages two and three
  // agree; costs one extra cycle but rejects a single-sample glitch
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_chan
      assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi]
                                                       : filt_q[gi];
      always @(posedge clock_in) begin
        if (rst_in) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          filt_q[gi]  <= 1'b0;
          proc_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          filt_q[gi]  <= filt_d[gi];
          if (pass_int[gi]) begin
            proc_q[gi] <= internal_clock_pulse_in;
          end else begin
            proc_q[gi] <= proc_fn(mode[3*gi+2:3*gi], filt_d[gi],
                                  filt_q[gi]);
          end
        end
      end
    end
  endgenerate

  // Clock bus count sources for the timers
  assign clock_bus_out = proc_q[3:0];
  // Event signals go both to the timers and to the event bus selectors
  assign event_out     = proc_q[8:4];

endmodule // tiesel_top

/* File: verif/tiesel_checker.sv */
// Port-level assertions for the timer input unit
`timescale 1ns/10ps
module tiesel_checker (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [3:0]  clock_bus_out,
  input wire logic [4:0]  event_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Reset is watched itself, so it may not disable this one
  reset_clear_a: assert property (disable iff (1'b0) rst_in |=>
    clock_bus_out == 4'h0 && event_out == 5'h00) else $error("outputs set");
  aw_block_a: assert property (s_axi_awvalid_in && s_axi_awready_out
    |=> !s_axi_awready_out) else $error("second write address taken");
  write_resp_a: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  b_drop_a: assert property (s_axi_bvalid_out && s_axi_bready_in
    |=> !s_axi_bvalid_out) else $error("write response repeated");
  bresp_code_a: assert property (s_axi_bvalid_out |-> s_axi_bresp_out
    inside {2'h0, 2'h2}) else $error("bad write response code");
  read_resp_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read data late");
  r_drop_a: assert property (s_axi_rvalid_out && s_axi_rready_in
    |=> !s_axi_rvalid_out) else $error("read data repeated");
  r_upper_a: assert property (s_axi_rvalid_out |->
    s_axi_rdata_out[31:16] == 16'h0000) else $error("upper data set");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while busy");
  cover property (clock_bus_out[1]);
  cover property (event_out[4]);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule // tiesel_checker
bind tiesel_top tiesel_checker u_chk (.*);

/* File: verif/tiesel_pin_model.sv */
// Behavioural model of the external timer pins
`timescale 1ns/10ps
module tiesel_pin_model (
  input  wire logic  clock_in,
  output logic [3:0] clk_pin_out,
  output logic [4:0] evt_pin_out,
  output logic       int_pulse_out
);
  // Pins start low; a driven pin holds its level, never floats
  initial {clk_pin_out, evt_pin_out, int_pulse_out} = 10'h000;
  task automatic drive(input logic [3:0] c, input logic [4:0] e,
                       input logic p);
    @(posedge clock_in);
    clk_pin_out <= c;
    evt_pin_out <= e;
    int_pulse_out <= p;
  endtask
endmodule // tiesel_pin_model

/* File: verif/tiesel_top_tb.sv */
// Self-checking bench for the timer input unit
`timescale 1ns/10ps
`include "tiesel_regs.vh"
module tiesel_top_tb;
  logic clock_in = 0, rst_in = 1, s_axi_bready_unused_in = 0;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic [31:0] s_axi_awaddr_in = '0, s_axi_wdata_in = '0, s_axi_araddr_in = '0;
  logic [3:0] s_axi_wstrb_in = '0;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire s_axi_arready_out, s_axi_rvalid_out, internal_clock_pulse_in;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [3:0] clock_bus_out, external_timer_clock_pin_in;
  wire [4:0] event_out, external_timer_event_pin_in;
  wire [8:0] outs = {event_out, clock_bus_out};
  int bad_count = 0, n_tests = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  tiesel_top DUT (.*);
  tiesel_pin_model PM (.clock_in, .clk_pin_out(external_timer_clock_pin_in),
    .evt_pin_out(external_timer_event_pin_in),
    .int_pulse_out(internal_clock_pulse_in));
  initial forever #5 clock_in = ~clock_in;
  task automatic results;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    results();
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Each channel is dropped as soon as its own ready is seen
  task automatic axi_wr(input logic [31:0] a, d);
    int n;
    @(posedge clock_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= 4'h3;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) break;
    end
    if (n == 50) hang();
    rs = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int n;
    @(posedge clock_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) break;
    end
    if (n == 50) hang();
    {rd, rs} = {s_axi_rdata_out, s_axi_rresp_out};
    s_axi_rready_in <= 1'b0;
  endtask
  // Code 0 on channels 0 and 3 passes the internal source a cycle late
  task automatic t_internal;
    PM.drive(4'h0, 5'h00, 1'b1);
    PM.drive(4'h0, 5'h00, 1'b0);
    #1 chk("int pass", clock_bus_out, 4'h9);
    @(posedge clock_in);
    #1 chk("int end", clock_bus_out, 4'h0);
  endtask
  // Reset values, writable bits and an unmapped place
  task automatic t_regs;
    axi_rd(`TIESEL_CLK_CTRL_ADDR);
    chk("clk reset", rd, 32'h0000_0000);
    axi_rd(`TIESEL_EVT_CTRL0_ADDR);
    chk("evt reset", rd, 32'h0000_0000);
    axi_wr(`TIESEL_CLK_CTRL_ADDR, 32'hffff_ffff);
    chk("wr okay", rs, `TIESEL_RESP_OKAY);
    axi_rd(`TIESEL_CLK_CTRL_ADDR);
    chk("clk mask", rd, 32'h0000_3773);
    axi_wr(`TIESEL_EVT_CTRL0_ADDR, 32'hffff_ffff);
    axi_rd(`TIESEL_EVT_CTRL0_ADDR);
    chk("evt mask", rd, 32'h0000_773f);
    axi_wr(32'h0000_0100, 32'hffff_ffff);
    chk("bad wr", rs, `TIESEL_RESP_SLVERR);
    axi_rd(32'h0000_0100);
    chk("bad rd", rd, 32'h0000_0000);
    chk("bad rresp", rs, `TIESEL_RESP_SLVERR);
  endtask
  // One code on one channel: a rising pin, then a falling pin
  task automatic t_mode(input logic [31:0] a, input int sh, pos,
                        input logic [2:0] code);
    int k, cnt;
    axi_wr(a, 32'(code) << sh);
    for (k = 0; k < 2; k++) begin
      PM.drive(k ? 4'h0 : 4'(9'h1 << pos), k ? 5'h00 : 5'((9'h1 << pos) >> 4),
               1'b0);
      cnt = 0;
      repeat (12) begin
        @(posedge clock_in);
        #1 cnt += outs[pos];
      end
      if (code < 3'h4) chk("pulses", cnt,
        k ? (code == 3'h2 || code == 3'h3) : (code == 3'h1 || code == 3'h3));
      chk("level", outs[pos], code[2:1] == (k ? 2'h2 : 2'h3));
    end
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    t_internal();
    t_regs();
    for (int c = 0; c < 4; c++) begin
      t_mode(`TIESEL_CLK_CTRL_ADDR, 0, 0, c);
      t_mode(`TIESEL_CLK_CTRL_ADDR, 12, 3, c);
      t_mode(`TIESEL_EVT_CTRL0_ADDR, 0, 4, c);
      t_mode(`TIESEL_EVT_CTRL0_ADDR, 2, 5, c);
      t_mode(`TIESEL_EVT_CTRL0_ADDR, 4, 6, c);
    end
    for (int c = 0; c < 8; c++) begin
      t_mode(`TIESEL_CLK_CTRL_ADDR, 4, 1, c);
      t_mode(`TIESEL_CLK_CTRL_ADDR, 8, 2, c);
      t_mode(`TIESEL_EVT_CTRL0_ADDR, 8, 7, c);
      t_mode(`TIESEL_EVT_CTRL0_ADDR, 12, 8, c);
    end
    results();
  end
endmodule // tiesel_top_tb
